// File: core/lcd_drive_control_registers.sv
`timescale 1ns/100ps
module lcd_drive_control_registers #(
    parameter int DW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host write port (strobe already synchronous to clk)
    input wire logic hostWrite,
    input wire logic regSelect,
    input wire logic [DW-1:0] hostData,
    // scan position from the timing generator
    input wire logic [6:0] scanRow,
    // drive outputs
    output logic drivePolarity,
    output logic [6:0] comLine,
    output logic [2:0] biasDenomMinus4,
    output logic [1:0] boostFactor,
    output logic boosterClockEnable,
    output logic [1:0] opampCurrentLevel,
    output logic analogRun,
    output logic oscillatorRun,
    output logic displayRun,
    output logic [5:0] contrastStep,
    output logic [8:0] resistanceTwentieths,
    output logic [1:0] fixedRowsSelect,
    output logic rowIsFixed,
    output logic doubleHeightActive,
    output logic [10:0] addressCounter
);
    // the rotate and combine functions are written for 16-bit words
    if (DW != 16) begin : gWidthCheck
        $error("only 16-bit words are served");
    end

    logic rstMeta_q, rstSync_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire resetN = rstSync_q;

    logic [4:0] index_q;
    logic [6:0] driverCfg_q;
    lcd_ctrl_pkg::wave_cfg_t wave_q;
    lcd_ctrl_pkg::power_cfg_t power_q;
    logic [5:0] contrast_q;
    lcd_ctrl_pkg::write_cfg_t wcfg_q;
    logic [5:0] display_q;
    logic [6:0] dhStart_q, dhEnd_q;
    logic [10:0] ac_q, acWr_q;
    logic pendWrite_q;
    logic [15:0] pendWord_q;

    wire inStandby = power_q.standbyHalt;
    wire inSleep = power_q.sleepEnable;
    wire locked = inStandby | inSleep;
    // index then data
    // standby freezes the index, so every data word lands in power control
    wire idxWrite = hostWrite & ~regSelect & ~inStandby;
    wire dataWrite = hostWrite & regSelect;
    wire powerWrite = dataWrite & (index_q == lcd_ctrl_pkg::IDX_POWER);
    wire otherWrite = dataWrite & ~locked;
    wire ramWrite = otherWrite & (index_q == lcd_ctrl_pkg::IDX_RAM_DATA);
    wire addrSetWrite = otherWrite & (index_q == lcd_ctrl_pkg::IDX_ADDR_SET);

    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            index_q <= 5'h00;
        end else if (idxWrite) begin
            index_q <= hostData[4:0];
        end
    end

    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            driverCfg_q <= 7'h00;
            wave_q <= '0;
            contrast_q <= 6'h00;
            wcfg_q <= 8'h80;
            display_q <= 6'h00;
            dhStart_q <= 7'h00;
            dhEnd_q <= 7'h00;
        end else if (otherWrite) begin
            unique case (index_q)
                lcd_ctrl_pkg::IDX_DRIVER_OUT: driverCfg_q <= {hostData[9], hostData[6], hostData[4:0]};
                lcd_ctrl_pkg::IDX_WAVEFORM: wave_q <= hostData[6:0];
                lcd_ctrl_pkg::IDX_CONTRAST: contrast_q <= hostData[5:0];
                lcd_ctrl_pkg::IDX_ENTRY: wcfg_q[7:3] <= hostData[4:0];
                lcd_ctrl_pkg::IDX_ROTATION: wcfg_q[2:0] <= hostData[2:0];
                lcd_ctrl_pkg::IDX_DISPLAY: display_q <= hostData[5:0];
                lcd_ctrl_pkg::IDX_DH_POS: begin
                    dhStart_q <= hostData[6:0];
                    dhEnd_q <= hostData[14:8];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            power_q <= '0;
        end else if (powerWrite) begin
            power_q <= {hostData[12:8], hostData[5:0]};
        end
    end

    // write datapath
    wire [15:0] ramRead;
    // a doubled word turns the rotate into a plain shift
    function automatic logic [15:0] rotl2(input logic [15:0] w, input logic [2:0] n);
        logic [31:0] dbl;
        dbl = {w, w} << {n, 1'b0};
        return dbl[31:16];
    endfunction
    function automatic logic [15:0] logicOp(input logic [15:0] a, input logic [15:0] b, input logic [1:0] op);
        logic [15:0] r;
        r = a;
        unique case (op)
            2'b00: r = a;
            2'b01: r = a | b;
            2'b10: r = a & b;
            2'b11: r = a ^ b;
        endcase
        return r;
    endfunction
    wire [15:0] rotated = rotl2(hostData, wcfg_q.writeRotateAmount);

    function automatic logic [10:0] nextAddr(input logic [10:0] a, input lcd_ctrl_pkg::write_cfg_t c);
        logic [10:0] s;
        s = a;
        unique case (c.addressUpdateDir)
            2'b01: s = c.stepUp ? a + 11'h010 : a - 11'h010;
            2'b10: s = c.stepUp ? (a[0] ? a + 11'h00f : a + 11'h001) : (a[0] ? a - 11'h001 : a - 11'h00f);
            default: s = c.stepUp ? a + 11'h001 : a - 11'h001;
        endcase
        return s;
    endfunction

    // read first cycle, combine and store next cycle
    // the address moves at the write edge; the store lands one edge later
    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            ac_q <= 11'h000;
            acWr_q <= 11'h000;
            pendWrite_q <= 1'b0;
            pendWord_q <= lcd_ctrl_pkg::RESET_ZERO;
        end else begin
            pendWrite_q <= ramWrite;
            if (ramWrite) begin
                pendWord_q <= rotated;
                acWr_q <= ac_q;
                ac_q <= nextAddr(ac_q, wcfg_q);
            end else if (addrSetWrite) begin
                ac_q <= hostData[10:0];
            end
        end
    end
    wire [15:0] storeWord = logicOp(pendWord_q, ramRead, wcfg_q.writeLogicOp);

    bitmap_ram #(.AW(lcd_ctrl_pkg::ADDR_W), .DW(16)) ramInst (
        .clk(clk),
        .wrEn(pendWrite_q),
        .wrAddr(acWr_q),
        .wrData(storeWord),
        .rdAddr(ac_q),
        .rdData(ramRead)
    );
    // the read latch samples ac_q at the write edge, so back-to-back writes each read their own cell

    // row timing and frame toggles
    // counters hold while sleep or standby halts the display
    logic [6:0] prevRow_q;
    logic frameOdd_q, groupOdd_q;
    logic [4:0] groupCnt_q;
    wire newRow = scanRow != prevRow_q;
    wire newFrame = newRow & (scanRow == 7'h00);
    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            prevRow_q <= 7'h00;
            frameOdd_q <= 1'b0;
            groupOdd_q <= 1'b0;
            groupCnt_q <= 5'h00;
        end else if (displayRun) begin
            prevRow_q <= scanRow;
            if (newFrame) begin
                frameOdd_q <= ~frameOdd_q;
            end
            if (newRow) begin
                // at or past the count, so a count lowered mid-group cannot wrap
                if (groupCnt_q >= wave_q.alternateRowCount) begin
                    groupCnt_q <= 5'h00;
                    groupOdd_q <= ~groupOdd_q;
                end else begin
                    groupCnt_q <= groupCnt_q + 5'h01;
                end
            end
        end
    end
    wire cPolarity = wave_q.xorAlternate ? (groupOdd_q ^ frameOdd_q) : groupOdd_q;

    logic [4:0] div_q;
    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            div_q <= 5'h00;
        end else if (oscillatorRun) begin
            div_q <= div_q + 5'h01;
        end
    end
    logic boostTick;
    always_comb begin
        unique case (power_q.boosterClockDivide)
            2'b00: boostTick = div_q == 5'h1f;
            2'b01: boostTick = div_q[3:0] == 4'hf;
            2'b10: boostTick = div_q[2:0] == 3'h7;
            2'b11: boostTick = div_q[1:0] == 2'h3;
        endcase
    end

    wire centerOn = driverCfg_q[5];
    wire scanReverse = driverCfg_q[6];
    wire [6:0] rotRow = centerOn ? 7'(scanRow + 7'(lcd_ctrl_pkg::CENTER_ROTATE * 3)) : scanRow;
    // reversed and centred, the first pin sits one line below the centre point and counts down
    wire [6:0] centerRev = 7'(7'(lcd_ctrl_pkg::CENTER_ROTATE * 3 - 1) - scanRow);
    wire [6:0] plainRev = 7'(lcd_ctrl_pkg::ROW_LAST - scanRow);
    wire [6:0] mapped = scanReverse ? (centerOn ? centerRev : plainRev) : rotRow;

    wire [6:0] fixedLimit = {2'b00, fixedRowsSelect, 3'b000};
    wire dhWindow = display_q[lcd_ctrl_pkg::DISP_DH_BIT] & (scanRow >= dhStart_q) & (scanRow <= dhEnd_q);

    always_ff @(posedge clk or negedge resetN) begin
        if (!resetN) begin
            drivePolarity <= 1'b0;
            comLine <= 7'h00;
            boosterClockEnable <= 1'b0;
            rowIsFixed <= 1'b0;
            doubleHeightActive <= 1'b0;
        end else begin
            drivePolarity <= wave_q.patternC ? cPolarity : frameOdd_q;
            comLine <= mapped;
            boosterClockEnable <= boostTick & analogRun;
            rowIsFixed <= scanRow < fixedLimit;
            doubleHeightActive <= dhWindow;
        end
    end

    assign biasDenomMinus4 = 3'(3'h7 - power_q.biasRatioSelect);
    assign boostFactor = power_q.boostFactor;
    assign opampCurrentLevel = power_q.opampCurrentLevel;
    assign analogRun = (power_q.opampCurrentLevel != 2'b00) & ~inStandby;
    assign contrastStep = contrast_q;
    assign resistanceTwentieths = 9'(9'd64 - {3'b000, contrast_q});
    assign oscillatorRun = ~inStandby;
    assign displayRun = ~locked;
    assign fixedRowsSelect = display_q[5:4];
    assign addressCounter = ac_q;
endmodule // lcd_drive_control_registers

// File: core/lcd_ctrl_pkg.sv
package lcd_ctrl_pkg;
    // register indexes written to the index register
    localparam logic [4:0] IDX_DRIVER_OUT = 5'h01;
    localparam logic [4:0] IDX_WAVEFORM = 5'h02;
    localparam logic [4:0] IDX_POWER = 5'h03;
    localparam logic [4:0] IDX_CONTRAST = 5'h04;
    localparam logic [4:0] IDX_ENTRY = 5'h05;
    localparam logic [4:0] IDX_ROTATION = 5'h06;
    localparam logic [4:0] IDX_DISPLAY = 5'h07;
    localparam logic [4:0] IDX_DH_POS = 5'h09;
    localparam logic [4:0] IDX_ADDR_SET = 5'h11;
    localparam logic [4:0] IDX_RAM_DATA = 5'h12;
    localparam logic [4:0] IDX_OSC_START = 5'h00;
    // field positions
    localparam int WAVE_PATTERN_BIT = 6;
    localparam int WAVE_XOR_BIT = 5;
    localparam int DRV_CENTER_BIT = 6;
    localparam int DRV_REVERSE_BIT = 9;
    localparam int PWR_SLEEP_BIT = 1;
    localparam int PWR_STANDBY_BIT = 0;
    localparam int ENTRY_SIGN_BIT = 4;
    localparam int DISP_DH_BIT = 3;
    localparam int DISP_ON_BIT = 0;
    // geometry
    localparam int NUM_ROWS = 128;
    localparam int CENTER_ROTATE = 32;
    localparam int ADDR_W = 11;
    localparam int WORDS_PER_ROW = 16;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [6:0] ROW_LAST = 7'h7f;
    // cycles per raster row of the internal scan
    localparam int ROW_CYCLES = 8;

    typedef struct packed {
        logic patternC;
        logic xorAlternate;
        logic [4:0] alternateRowCount;
    } wave_cfg_t;

    typedef struct packed {
        logic [2:0] biasRatioSelect;
        logic [1:0] boostFactor;
        logic [1:0] boosterClockDivide;
        logic [1:0] opampCurrentLevel;
        logic sleepEnable;
        logic standbyHalt;
    } power_cfg_t;

    typedef struct packed {
        logic stepUp;
        logic [1:0] addressUpdateDir;
        logic [1:0] writeLogicOp;
        logic [2:0] writeRotateAmount;
    } write_cfg_t;
endpackage

// File: core/bitmap_ram.sv
`timescale 1ns/100ps
module bitmap_ram #(
    parameter int AW = 11,
    parameter int DW = 16
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    // read port
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // bitmap_ram

// File: tb/lcd_drive_control_registers_asserts.sv
`timescale 1ns/100ps
module lcd_drive_control_registers_asserts #(
    parameter int DW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host side
    input wire logic hostWrite,
    input wire logic regSelect,
    input wire logic [DW-1:0] hostData,
    input wire logic [6:0] scanRow,
    // drive side
    input wire logic drivePolarity,
    input wire logic [6:0] comLine,
    input wire logic [2:0] biasDenomMinus4,
    input wire logic [1:0] boostFactor,
    input wire logic boosterClockEnable,
    input wire logic [1:0] opampCurrentLevel,
    input wire logic analogRun,
    input wire logic oscillatorRun,
    input wire logic displayRun,
    input wire logic [5:0] contrastStep,
    input wire logic [8:0] resistanceTwentieths,
    input wire logic [1:0] fixedRowsSelect,
    input wire logic rowIsFixed,
    input wire logic doubleHeightActive,
    input wire logic [10:0] addressCounter
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // three quiet cycles cover the one-edge lag of registered outputs
    sequence idleBus;
        (!hostWrite)[*3];
    endsequence
    sequence ampDown;
        (!analogRun)[*3];
    endsequence

    ac_write_only_a: assert property (idleBus |=> $stable(addressCounter))
        else $error("address counter moved without a write");
    cfg_hold_a: assert property ((!hostWrite)[*2] |=> $stable({contrastStep, opampCurrentLevel}))
        else $error("settings changed without a write");
    contrast_map_a: assert property (resistanceTwentieths == 9'h040 - {3'h0, contrastStep})
        else $error("resistance does not follow contrast code");
    amp_off_a: assert property (opampCurrentLevel == 2'h0 |-> !analogRun)
        else $error("amplifier runs with current code zero");
    booster_stop_a: assert property (ampDown |-> !boosterClockEnable)
        else $error("booster ticks while stopped");
    tick_gap_a: assert property (boosterClockEnable |=> (!boosterClockEnable)[*3])
        else $error("booster ticks closer than divide by four");
    standby_stop_a: assert property (!oscillatorRun |-> !analogRun && !displayRun)
        else $error("activity while oscillator halted");
    sleep_osc_a: assert property (displayRun |-> oscillatorRun)
        else $error("display runs without oscillator");
    fixed_rows_a: assert property ($stable(scanRow) && $stable(fixedRowsSelect)
        |-> rowIsFixed == (scanRow < {2'h0, fixedRowsSelect, 3'h0}))
        else $error("fixed row flag wrong");
endmodule // lcd_drive_control_registers_asserts

// File: tb/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
    // clock
    input wire logic clk,
    // bus toward the block
    output logic hostWrite,
    output logic regSelect,
    output logic [15:0] hostData
);
    initial begin
        hostWrite = 1'b0;
        regSelect = 1'b0;
        hostData = 16'h0000;
    end
    // released data is inverted so a stale word never looks valid
    task automatic put(input logic rs, input logic [15:0] d);
        @(posedge clk);
        hostWrite <= 1'b1;
        regSelect <= rs;
        hostData <= d;
        @(posedge clk);
        hostWrite <= 1'b0;
        hostData <= ~d;
    endtask
    task automatic writeReg(input logic [4:0] idx, input logic [15:0] d);
        put(1'b0, {11'h000, idx});
        put(1'b1, d);
    endtask
endmodule // host_bus_model

// File: tb/lcd_drive_control_registers_tb.sv
`timescale 1ns/100ps
module lcd_drive_control_registers_tb;
    logic clk = 1'b0;
    logic rst_b;
    logic hostWrite, regSelect, polPrev;
    logic [15:0] hostData;
    logic [6:0] scanRow = 7'h00;
    logic drivePolarity, boosterClockEnable, analogRun, oscillatorRun, displayRun, rowIsFixed, doubleHeightActive;
    logic [6:0] comLine;
    logic [2:0] biasDenomMinus4;
    logic [1:0] boostFactor, opampCurrentLevel, fixedRowsSelect;
    logic [5:0] contrastStep;
    logic [8:0] resistanceTwentieths;
    logic [10:0] addressCounter;
    int badCount = 0;
    int samplesChecked = 0;
    int toggles = 0;
    int ticks = 0;
    int t0;

    always #50 clk = ~clk;
    host_bus_model host_u (.*);
    lcd_drive_control_registers #(.DW(16)) dut_u (.*);

    always @(posedge clk) begin
        polPrev <= drivePolarity;
        if (drivePolarity !== polPrev) begin
            toggles <= toggles + 1;
        end
        if (boosterClockEnable === 1'b1) begin
            ticks <= ticks + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        host_u.writeReg(idx, d);
        tick(2);
    endtask
    task automatic setRow(input logic [6:0] r);
        @(posedge clk);
        scanRow <= r;
        tick(2);
    endtask
    // rows advance every second cycle so the group counter sees each change
    task automatic sweep(input int n);
        repeat (n) begin
            @(posedge clk);
            scanRow <= scanRow + 7'h01;
            @(posedge clk);
        end
        tick(2);
    endtask

    task automatic powerCodes;
        for (int i = 0; i < 8; i++) begin
            wr(lcd_ctrl_pkg::IDX_POWER, {3'h0, i[2:0], i[1:0], 2'h0, ~i[1:0], i[1:0], 2'h0});
            t0 = ticks;
            tick(128);
            check(biasDenomMinus4, 16'(7 - i));
            check(boostFactor, i[1:0]);
            check(opampCurrentLevel, i[1:0]);
            check(analogRun, i[1:0] != 2'h0);
            check(16'(ticks - t0), (i % 4 == 0) ? 16'h0000 : 16'(4 << (3 - i % 4)));
        end
    endtask
    task automatic sleepStandby;
        wr(lcd_ctrl_pkg::IDX_CONTRAST, 16'h0005);
        wr(lcd_ctrl_pkg::IDX_POWER, 16'h0002);
        check(displayRun, 1'b0);
        check(oscillatorRun, 1'b1);
        wr(lcd_ctrl_pkg::IDX_CONTRAST, 16'h0009);
        check(contrastStep, 6'h05);
        wr(lcd_ctrl_pkg::IDX_POWER, 16'h0001);
        check(oscillatorRun, 1'b0);
        // index refused in standby, so this word lands in power control
        wr(lcd_ctrl_pkg::IDX_CONTRAST, 16'h0000);
        check(oscillatorRun, 1'b1);
        check(contrastStep, 6'h05);
        wr(lcd_ctrl_pkg::IDX_CONTRAST, 16'h0009);
        check(contrastStep, 6'h09);
    endtask
    task automatic contrastCodes;
        for (int j = 0; j < 4; j++) begin
            wr(lcd_ctrl_pkg::IDX_CONTRAST, 16'(j * 21));
            check(contrastStep, 16'(j * 21));
            check(resistanceTwentieths, 16'(64 - j * 21));
        end
    endtask
    task automatic addressWalk;
        wr(lcd_ctrl_pkg::IDX_ADDR_SET, 16'h0010);
        wr(lcd_ctrl_pkg::IDX_ROTATION, 16'h0007);
        wr(lcd_ctrl_pkg::IDX_ENTRY, 16'h0010);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h1234);
        host_u.put(1'b1, 16'h8001);
        tick(2);
        check(addressCounter, 16'h0012);
        check(dut_u.ramInst.mem[11'h010], 16'h048d);
        check(dut_u.ramInst.mem[11'h011], 16'h6000);
        wr(lcd_ctrl_pkg::IDX_ENTRY, 16'h0001);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h00ff);
        check(addressCounter, 16'h0011);
        wr(lcd_ctrl_pkg::IDX_ENTRY, 16'h0016);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h5a5a);
        check(addressCounter, 16'h0021);
        check(dut_u.ramInst.mem[11'h011], 16'h0000);
        wr(lcd_ctrl_pkg::IDX_ADDR_SET, 16'h0020);
        wr(lcd_ctrl_pkg::IDX_ENTRY, 16'h0018);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h0001);
        check(addressCounter, 16'h0021);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h0002);
        check(addressCounter, 16'h0030);
        wr(lcd_ctrl_pkg::IDX_ADDR_SET, 16'h0010);
        wr(lcd_ctrl_pkg::IDX_ENTRY, 16'h0011);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h0003);
        check(dut_u.ramInst.mem[11'h010], 16'hc48d);
        wr(lcd_ctrl_pkg::IDX_ADDR_SET, 16'h0010);
        wr(lcd_ctrl_pkg::IDX_ENTRY, 16'h0013);
        wr(lcd_ctrl_pkg::IDX_RAM_DATA, 16'h0003);
        check(dut_u.ramInst.mem[11'h010], 16'h048d);
    endtask
    task automatic displayRows;
        wr(lcd_ctrl_pkg::IDX_DH_POS, 16'h140a);
        for (int p = 1; p < 4; p++) begin
            wr(lcd_ctrl_pkg::IDX_DISPLAY, 16'(p * 16 + 8));
            check(fixedRowsSelect, 16'(p));
            for (int r = 6; r < 26; r++) begin
                setRow(7'(r));
                check(rowIsFixed, r < 8 * p);
                check(doubleHeightActive, r >= 10 && r <= 20);
            end
        end
    endtask
    task automatic comMap;
        logic [6:0] e;
        logic [6:0] k;
        for (int m = 0; m < 4; m++) begin
            wr(lcd_ctrl_pkg::IDX_DRIVER_OUT, {6'h00, m[1], 2'h0, m[0], 6'h00});
            for (int j = 0; j < 3; j++) begin
                k = 7'(j * 48 + 5);
                setRow(k);
                e = m[0] ? k + 7'h60 : k;
                if (m[1]) begin
                    e = m[0] ? 7'h5f - k : 7'h7f - k;
                end
                check(comLine, e);
            end
        end
    endtask
    task automatic waveform;
        setRow(7'h00);
        wr(lcd_ctrl_pkg::IDX_WAVEFORM, 16'h0000);
        t0 = toggles;
        sweep(100);
        check(16'(toggles - t0), 16'h0000);
        sweep(28);
        check(16'(toggles - t0), 16'h0001);
        wr(lcd_ctrl_pkg::IDX_WAVEFORM, 16'h0041);
        t0 = toggles;
        sweep(24);
        check(16'(toggles - t0), 16'h000c);
        wr(lcd_ctrl_pkg::IDX_WAVEFORM, 16'h005f);
        setRow(7'h00);
        t0 = toggles;
        sweep(96);
        check(16'(toggles - t0), 16'h0003);
        // every row flips the group; the frame wrap cancels one flip
        wr(lcd_ctrl_pkg::IDX_WAVEFORM, 16'h0060);
        t0 = toggles;
        sweep(128);
        check(16'(toggles - t0), 16'h007f);
    endtask

    task automatic finalReport;
        $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        // driven at time zero so the reset edge is seen
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        tick(4);
        powerCodes();
        sleepStandby();
        contrastCodes();
        addressWalk();
        displayRows();
        comMap();
        waveform();
        finalReport();
    end
    // run needs about 2300 cycles
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        finalReport();
    end
endmodule // lcd_drive_control_registers_tb

bind lcd_drive_control_registers lcd_drive_control_registers_asserts #(.DW(DW)) chk_u (.*);
